// ---- logic/fpsw_pkg.sv ----
/*
  Shared constants for the flash status-word polling controller.
  Assumes a 10 MHz system clock and a 16-bit asynchronous NOR flash.
*/
`default_nettype none
package fpsw_pkg;
  // ------------------------------------------------------------------
  // Clock and pin timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ  = 10;
  localparam int T_ACC_NS = 100;
  localparam int T_WP_NS  = 35;
  localparam int T_PH_NS  = 20;
  localparam int SYNC_CYC = 2;

  // Least times round up and never fall under one cycle.
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACC_CYC    = ns_to_cyc(T_ACC_NS);
  localparam int RD_LOW_CYC = ACC_CYC + SYNC_CYC;
  localparam int WP_CYC     = ns_to_cyc(T_WP_NS);
  localparam int PH_CYC     = ns_to_cyc(T_PH_NS);
  localparam int CNT_W      = 4;

  // ------------------------------------------------------------------
  // Flash bus and status word layout
  // ------------------------------------------------------------------
  localparam int ADDR_W   = 26;
  localparam int DQ_W     = 16;
  localparam int POL_BIT  = 7;
  localparam int ACT_BIT  = 6;
  localparam int TMO_BIT  = 5;
  localparam int ERS_BIT  = 3;
  localparam int SEC_BIT  = 2;
  localparam int ABT_BIT  = 1;
  localparam logic [15:0] STAT_MASK = 16'h00ee;

  function automatic logic [15:0] status_mask(input logic [15:0] w);
    return w & STAT_MASK;
  endfunction

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_EXPECT = 8'h08;
  localparam logic [7:0] REG_RSTCMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_LAST   = 8'h14;
  localparam logic [7:0] REG_DATA   = 8'h18;

  localparam int CTRL_START  = 0;
  localparam int CTRL_TOGGLE = 1;
  localparam int CTRL_STOP   = 2;
  localparam int CTRL_BUF    = 3;

  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_PASS = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_TMO  = 4;
  localparam int ST_ABT  = 5;
  localparam int ST_ERS  = 6;

  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic [15:0] RSTCMD_RST = 16'h0000;
endpackage
`default_nettype wire

// ---- logic/fpsw_cycle.sv ----
/*
  One asynchronous flash read or write cycle per start pulse.
  Assumes the flash data pins are resolved outside from the enable.
*/
`timescale 1ns/100ps
`default_nettype none
module fpsw_cycle (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       start,
  input  wire logic                       is_write,
  input  wire logic [fpsw_pkg::ADDR_W-1:0] addr,
  input  wire logic [fpsw_pkg::DQ_W-1:0]   wdata,
  output logic                            done,
  output logic      [fpsw_pkg::DQ_W-1:0]   rdata,
  output logic      [fpsw_pkg::ADDR_W-1:0] flash_addr,
  output logic      [fpsw_pkg::DQ_W-1:0]   flash_dq_o,
  output logic                            flash_dq_oe,
  input  wire logic [fpsw_pkg::DQ_W-1:0]   flash_dq_i,
  output logic                            flash_ce_n,
  output logic                            flash_oe_n,
  output logic                            flash_we_n
);
  typedef enum logic [3:0] {
    C_IDLE  = 4'h1,
    C_SETUP = 4'h2,
    C_LOW   = 4'h4,
    C_HIGH  = 4'h8
  } fpsw_cyc_t;

  localparam logic [3:0] RD_LOW = 4'(fpsw_pkg::RD_LOW_CYC);
  localparam logic [3:0] WP     = 4'(fpsw_pkg::WP_CYC);
  localparam logic [3:0] PH     = 4'(fpsw_pkg::PH_CYC);

  fpsw_cyc_t          st_q, st_d;
  logic [3:0]         cnt_q, cnt_d;
  logic               wr_q, wr_d;
  logic [15:0]        rdata_d;
  logic [25:0]        addr_d;
  logic [15:0]        dqo_d;
  logic               oe_d, ce_d, oen_d, wen_d, done_d;
  logic [15:0]        dq_s1_q, dq_s2_q;

  // ------------------------------------------------------------------
  // Pin input synchroniser
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------------
  // The strobe stays low for the access time plus the two sync stages,
  // so the sampled word is settled; this costs two cycles per read.
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    rdata_d = rdata;
    addr_d  = flash_addr;
    dqo_d   = flash_dq_o;
    oe_d    = flash_dq_oe;
    ce_d    = flash_ce_n;
    oen_d   = flash_oe_n;
    wen_d   = flash_we_n;
    done_d  = 1'b0;
    case (st_q)
      C_IDLE: begin
        if (start) begin
          addr_d = addr;
          wr_d   = is_write;
          dqo_d  = wdata;
          oe_d   = is_write;
          st_d   = C_SETUP;
        end
      end
      C_SETUP: begin
        ce_d  = 1'b0;
        oen_d = wr_q;
        wen_d = !wr_q;
        cnt_d = wr_q ? WP : RD_LOW;
        st_d  = C_LOW;
      end
      C_LOW: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          if (!wr_q) begin
            rdata_d = dq_s2_q;
          end
          ce_d  = 1'b1;
          oen_d = 1'b1;
          wen_d = 1'b1;
          cnt_d = PH;
          st_d  = C_HIGH;
        end
      end
      default: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          oe_d   = 1'b0;
          done_d = 1'b1;
          st_d   = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q        <= C_IDLE;
      cnt_q       <= 4'h0;
      wr_q        <= 1'b0;
      rdata       <= 16'h0000;
      flash_addr  <= 26'h0000000;
      flash_dq_o  <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      done        <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      wr_q        <= wr_d;
      rdata       <= rdata_d;
      flash_addr  <= addr_d;
      flash_dq_o  <= dqo_d;
      flash_dq_oe <= oe_d;
      flash_ce_n  <= ce_d;
      flash_oe_n  <= oen_d;
      flash_we_n  <= wen_d;
      done        <= done_d;
    end
  end

  a_strobe_excl: assert property (@(posedge clock) disable iff (!rst_n)
    !(!flash_oe_n && !flash_we_n))
    else $error("Output and write strobes low together.");

  a_read_width: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n)[*3] ##1 flash_oe_n)
    else $error("Read strobe width is wrong.");

  a_no_contend: assert property (@(posedge clock) disable iff (!rst_n)
    flash_dq_oe |-> flash_oe_n)
    else $error("Data driven while flash output enabled.");
endmodule
`default_nettype wire

// ---- logic/fpsw_top.sv ----
/*
  Host controller that polls the flash status word over the async bus.
  Assumes an APB master on the same 10 MHz clock and one flash device.
*/
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Mask status bits 15-8, 4 and 0.
// - Poll erase status inside the erased sector.
// - Take array data only on a later read.
// - Polarity valid only at the operation address.
// - Recheck polarity even when timeout reads 1.
// - Confirm busy before trusting erase-started bit.
// - Read twice, compare toggle; same means done.
// - Toggling with timeout: recheck, then reset.
// - Resumed polling restarts from first step.
module fpsw_top (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic      [fpsw_pkg::ADDR_W-1:0] flash_addr,
  output logic      [fpsw_pkg::DQ_W-1:0]   flash_dq_o,
  output logic                            flash_dq_oe,
  input  wire logic [fpsw_pkg::DQ_W-1:0]   flash_dq_i,
  output logic                            flash_ce_n,
  output logic                            flash_oe_n,
  output logic                            flash_we_n
);
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_R1   = 6'h02,
    S_R2   = 6'h04,
    S_RCHK = 6'h08,
    S_DATA = 6'h10,
    S_RST  = 6'h20
  } fpsw_st_t;

  fpsw_st_t     st_q, st_d;
  logic [3:0]   ctrl_q, ctrl_d;
  logic [25:0]  addr_q, addr_d;
  logic         exp_q, exp_d;
  logic [15:0]  rcmd_q, rcmd_d;
  logic [15:0]  prev_q, prev_d, last_q, last_d, data_q, data_d;
  logic [6:0]   stat_q, stat_d;
  logic         cstart_q, cstart_d, cwr_q, cwr_d;
  logic [31:0]  prdata_d;
  logic         pready_d, pslverr_d;
  logic         cyc_done;
  logic [15:0]  cyc_rdata, cur;
  logic         apb_wr, go, set_done, same;

  fpsw_cycle u_cycle (
    .clock       (clock),
    .rst_n       (rst_n),
    .start       (cstart_q),
    .is_write    (cwr_q),
    .addr        (addr_q),
    .wdata       (rcmd_q),
    .done        (cyc_done),
    .rdata       (cyc_rdata),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n)
  );

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // One wait state: the answer is registered so every output is a flop.
  assign apb_wr = psel && penable && pwrite && pready;
  assign go     = apb_wr && (paddr == fpsw_pkg::REG_CTRL)
                  && pwdata[fpsw_pkg::CTRL_START] && (st_q == S_IDLE);

  always_comb begin
    pready_d  = psel && penable && !pready;
    pslverr_d = 1'b0;
    prdata_d  = 32'h00000000;
    ctrl_d    = ctrl_q;
    addr_d    = addr_q;
    exp_d     = exp_q;
    rcmd_d    = rcmd_q;
    if (paddr == fpsw_pkg::REG_CTRL) begin
      prdata_d[3:1] = ctrl_q[3:1];
    end else if (paddr == fpsw_pkg::REG_ADDR) begin
      prdata_d[25:0] = addr_q;
    end else if (paddr == fpsw_pkg::REG_EXPECT) begin
      prdata_d[0] = exp_q;
    end else if (paddr == fpsw_pkg::REG_RSTCMD) begin
      prdata_d[15:0] = rcmd_q;
    end else if (paddr == fpsw_pkg::REG_STATUS) begin
      prdata_d[6:0] = stat_q;
    end else if (paddr == fpsw_pkg::REG_LAST) begin
      prdata_d[15:0] = last_q;
    end else if (paddr == fpsw_pkg::REG_DATA) begin
      prdata_d[15:0] = data_q;
    end else begin
      pslverr_d = pready_d;
    end
    if (!pready_d) begin
      prdata_d = 32'h00000000;
    end
    if (apb_wr) begin
      if (paddr == fpsw_pkg::REG_CTRL) begin
        ctrl_d = {pwdata[3:1], 1'b0};
      end else if (paddr == fpsw_pkg::REG_ADDR) begin
        addr_d = pwdata[25:0];
      end else if (paddr == fpsw_pkg::REG_EXPECT) begin
        exp_d = pwdata[0];
      end else if (paddr == fpsw_pkg::REG_RSTCMD) begin
        rcmd_d = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      ctrl_q  <= fpsw_pkg::CTRL_RST;
      addr_q  <= 26'h0000000;
      exp_q   <= 1'b0;
      rcmd_q  <= fpsw_pkg::RSTCMD_RST;
    end else begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
      ctrl_q  <= ctrl_d;
      addr_q  <= addr_d;
      exp_q   <= exp_d;
      rcmd_q  <= rcmd_d;
    end
  end

  // ------------------------------------------------------------------
  // Polling sequencer
  // ------------------------------------------------------------------
  assign cur  = fpsw_pkg::status_mask(cyc_rdata);
  assign same = ctrl_q[fpsw_pkg::CTRL_TOGGLE]
                ? (cur[fpsw_pkg::ACT_BIT] == prev_q[fpsw_pkg::ACT_BIT])
                : (cur[fpsw_pkg::POL_BIT] == exp_q);

  always_comb begin
    st_d     = st_q;
    prev_d   = prev_q;
    last_d   = last_q;
    data_d   = data_q;
    stat_d   = stat_q;
    cstart_d = 1'b0;
    cwr_d    = 1'b0;
    set_done = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (go) begin
          stat_d   = 7'h01;
          cstart_d = 1'b1;
          // A fresh start begins with the first read pair in toggle mode only; polarity mode goes straight to S_R2.
          st_d     = pwdata[fpsw_pkg::CTRL_TOGGLE] ? S_R1 : S_R2;
        end
      end
      S_R1: begin
        if (cyc_done) begin
          prev_d   = cur;
          last_d   = cur;
          cstart_d = 1'b1;
          st_d     = S_R2;
        end
      end
      S_R2: begin
        if (cyc_done) begin
          prev_d = cur;
          last_d = cur;
          if (ctrl_q[fpsw_pkg::CTRL_STOP]) begin
            stat_d[fpsw_pkg::ST_BUSY] = 1'b0;
            st_d = S_IDLE;
          end else if (same) begin
            cstart_d = 1'b1;
            st_d     = S_DATA;
          end else if (ctrl_q[fpsw_pkg::CTRL_BUF]
                       && cur[fpsw_pkg::ABT_BIT]) begin
            stat_d[fpsw_pkg::ST_ABT]  = 1'b1;
            stat_d[fpsw_pkg::ST_FAIL] = 1'b1;
            stat_d[fpsw_pkg::ST_BUSY] = 1'b0;
            set_done = 1'b1;
            st_d     = S_IDLE;
          end else begin
            // Of two differing toggle reads the first is surely status.
            stat_d[fpsw_pkg::ST_ERS] = ctrl_q[fpsw_pkg::CTRL_TOGGLE]
                ? prev_q[fpsw_pkg::ERS_BIT] : cur[fpsw_pkg::ERS_BIT];
            cstart_d = 1'b1;
            if (cur[fpsw_pkg::TMO_BIT]) begin
              stat_d[fpsw_pkg::ST_TMO] = 1'b1;
              st_d = S_RCHK;
            end
          end
        end
      end
      S_RCHK: begin
        if (cyc_done) begin
          last_d   = cur;
          cstart_d = 1'b1;
          if (same) begin
            st_d = S_DATA;
          end else begin
            cwr_d = 1'b1;
            st_d  = S_RST;
          end
        end
      end
      S_DATA: begin
        if (cyc_done) begin
          data_d = cyc_rdata;
          stat_d[fpsw_pkg::ST_PASS] = 1'b1;
          stat_d[fpsw_pkg::ST_BUSY] = 1'b0;
          set_done = 1'b1;
          st_d     = S_IDLE;
        end
      end
      default: begin
        if (cyc_done) begin
          stat_d[fpsw_pkg::ST_FAIL] = 1'b1;
          stat_d[fpsw_pkg::ST_BUSY] = 1'b0;
          set_done = 1'b1;
          st_d     = S_IDLE;
        end
      end
    endcase
    if (set_done) begin
      stat_d[fpsw_pkg::ST_DONE] = 1'b1;
    end else if (apb_wr && (paddr == fpsw_pkg::REG_STATUS)
                 && pwdata[fpsw_pkg::ST_DONE]) begin
      stat_d[fpsw_pkg::ST_DONE] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q     <= S_IDLE;
      prev_q   <= 16'h0000;
      last_q   <= 16'h0000;
      data_q   <= 16'h0000;
      stat_q   <= 7'h00;
      cstart_q <= 1'b0;
      cwr_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      prev_q   <= prev_d;
      last_q   <= last_d;
      data_q   <= data_d;
      stat_q   <= stat_d;
      cstart_q <= cstart_d;
      cwr_q    <= cwr_d;
    end
  end

  a_apb_wait: assert property (@(posedge clock) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("APB answer not after one wait state.");

  a_err_unmapped: assert property (@(posedge clock) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("Error answer without ready.");

  a_mask_last: assert property (@(posedge clock) disable iff (!rst_n)
    (last_q & ~fpsw_pkg::STAT_MASK) == 16'h0000)
    else $error("Unmasked status bits stored.");

  a_data_later: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(stat_q[fpsw_pkg::ST_PASS]) |-> $past(st_q) == S_DATA)
    else $error("Pass without a following array read.");

  a_fail_reset: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == S_RCHK && cyc_done && !same)
    |=> cstart_q && cwr_q ##1 st_q == S_RST)
    else $error("Reset command not issued after recheck failure.");

  a_recheck_tmo: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == S_R2 && cyc_done && !same && !ctrl_q[fpsw_pkg::CTRL_STOP]
     && !(ctrl_q[fpsw_pkg::CTRL_BUF] && cur[fpsw_pkg::ABT_BIT])
     && cur[fpsw_pkg::TMO_BIT]) |=> st_q == S_RCHK)
    else $error("Timeout seen without recheck.");

  a_two_reads: assert property (@(posedge clock) disable iff (!rst_n)
    (go && pwdata[fpsw_pkg::CTRL_TOGGLE]) |=> st_q == S_R1)
    else $error("Toggle polling did not start with first read.");

  a_done_sets: assert property (@(posedge clock) disable iff (!rst_n)
    set_done |=> stat_q[fpsw_pkg::ST_DONE] && !stat_q[fpsw_pkg::ST_BUSY])
    else $error("Done flag lost or busy stuck.");
endmodule
`default_nettype wire

// ---- tb/fpsw_flash_model.sv ----
/*
  Behavioural flash device that serves polling status while busy.
  Assumes the controller drives one strobe set and the bench resolves the data bus.
*/
`timescale 1ns/100ps
`default_nettype none
module fpsw_flash_model (
  input  wire logic [fpsw_pkg::ADDR_W-1:0] addr,
  input  wire logic [fpsw_pkg::DQ_W-1:0]   dq_in,
  input  wire logic                        ce_n,
  input  wire logic                        oe_n,
  input  wire logic                        we_n,
  output logic      [fpsw_pkg::DQ_W-1:0]   dq_out
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic        busy, erase, tog6, tog2, tmo, abt, frozen;
  logic [15:0] word, last, cmd, noise, stat;
  logic [25:0] op_addr, cmd_addr;
  int          left, tmo_mode, resets;
  wire         rd_on  = !ce_n && !oe_n;
  wire         in_sec = addr[25:16] == op_addr[25:16];

  initial begin
    busy = 1'b0; erase = 1'b0; tog6 = 1'b0; tog2 = 1'b0; tmo = 1'b0;
    abt = 1'b0; frozen = 1'b0; word = 16'h0000; last = 16'h0000;
    cmd = 16'h0000; noise = 16'h2c41; op_addr = 26'h0; cmd_addr = 26'h0;
    left = 0; tmo_mode = 0; resets = 0;
  end

  // Mode 1 never finishes; mode 2 stops toggling when the count runs out, with the flag up from arm.
  task automatic arm(input logic er, input int n, input logic [15:0] w,
                     input int tm, input logic ab, input logic [25:0] a);
    erase = er; left = n; word = w; tmo_mode = tm; tmo = (tm != 0);
    abt = ab; op_addr = a; frozen = 1'b0; busy = 1'b1;
  endtask

  // ------------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------------
  always_comb begin
    stat    = noise & 16'hff11;
    stat[7] = erase ? 1'b0 : ~word[7];
    stat[6] = tog6;
    stat[5] = tmo;
    stat[3] = erase;
    stat[2] = erase && in_sec && tog2;
    stat[1] = abt;
  end
  // Released bus shows the inverse so a stale sample cannot match.
  assign dq_out = rd_on ? (busy ? stat : word) : ~last;

  // ------------------------------------------------------------------
  // Read end and reset command
  // ------------------------------------------------------------------
  always @(posedge (ce_n | oe_n)) begin
    last  = busy ? stat : word;
    noise = noise + 16'h1357;
    // The count is taken first, so a freeze also stops this read's toggle.
    if (busy && left > 0) begin
      left = left - 1;
      if (left == 0 && tmo_mode == 2)
        frozen = 1'b1;
      else if (left == 0 && tmo_mode == 0 && !abt)
        busy = 1'b0;
    end else if (frozen) begin
      busy = 1'b0;
    end
    if (busy && !frozen) begin
      tog6 = ~tog6;
      if (erase && in_sec)
        tog2 = ~tog2;
    end
  end

  always @(posedge we_n) begin
    cmd = dq_in; cmd_addr = addr; resets = resets + 1;
    busy = 1'b0; tmo = 1'b0; frozen = 1'b0;
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  Self-checking bench: APB tasks drive polling operations against a flash
  model. Assumes the controller answers APB with the handshake in its note.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [25:0] OPA = 26'h0150004;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [25:0] flash_addr;
  logic [15:0] flash_dq_o, model_dq, flash_dq_i;
  logic        flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, errv;
  int          miscompares, samples_checked, rs0;
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : model_dq;

  fpsw_top fpsw_top_i (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n));
  fpsw_flash_model fpsw_flash_model_i (.addr(flash_addr),
    .dq_in(flash_dq_o), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .dq_out(model_dq));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic close_out();
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask

  // Expected status: [6]erase [5]abort [4]timeout [3]fail [2]pass [1]done.
  task automatic run_op(input string name, input logic [3:0] mode,
                        input logic er, input int n, input logic [15:0] w,
                        input int tm, input logic ab, input logic [6:0] st);
    int k;
    k = 0;
    rs0 = fpsw_flash_model_i.resets;
    fpsw_flash_model_i.arm(er, n, w, tm, ab, OPA);
    wr(fpsw_pkg::REG_EXPECT, {31'h0, w[7]});
    wr(fpsw_pkg::REG_CTRL, {28'h0, mode | 4'h1});
    rdv = 32'h0;
    while (rdv[fpsw_pkg::ST_DONE] !== 1'b1 && k < 300) begin
      apb(1'b0, fpsw_pkg::REG_STATUS, 32'h0, rdv, errv);
      k++;
    end
    if (k >= 300) begin
      miscompares++;
      close_out();
    end
    check({name, " status"}, rdv, {25'h0, st});
    if (st[2]) begin
      apb(1'b0, fpsw_pkg::REG_DATA, 32'h0, rdv, errv);
      check({name, " data"}, rdv, {16'h0, w});
    end
    check({name, " resets"}, fpsw_flash_model_i.resets - rs0,
          {31'h0, st[3] & ~st[5]});
    wr(fpsw_pkg::REG_STATUS, 32'h2);
    apb(1'b0, fpsw_pkg::REG_STATUS, 32'h0, rdv, errv);
    check({name, " done clear"}, rdv[1], 32'h0);
    $display("Test %s finished", name);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    miscompares = 0; samples_checked = 0; rs0 = 0;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; rdv = 32'h0; errv = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, fpsw_pkg::REG_CTRL, 32'h0, rdv, errv);
    check("ctrl reset", rdv, {28'h0, fpsw_pkg::CTRL_RST});
    apb(1'b0, fpsw_pkg::REG_RSTCMD, 32'h0, rdv, errv);
    check("rstcmd reset", rdv, {16'h0, fpsw_pkg::RSTCMD_RST});
    apb(1'b0, 8'h1c, 32'h0, rdv, errv);
    check("unmapped err", {31'h0, errv}, 32'h1);
    check("unmapped data", rdv, 32'h0);
    $display("Test registers finished");
    wr(fpsw_pkg::REG_ADDR, {6'h0, OPA});
    wr(fpsw_pkg::REG_RSTCMD, 32'h000000f0);
    run_op("prog_pol_0", 4'h0, 1'b0, 3, 16'h1234, 0, 1'b0, 7'h06);
    run_op("prog_pol_1", 4'h0, 1'b0, 1, 16'h00a5, 0, 1'b0, 7'h06);
    run_op("erase_pol", 4'h0, 1'b1, 4, 16'hffff, 0, 1'b0, 7'h46);
    run_op("prog_tog", 4'h2, 1'b0, 5, 16'h5a5a, 0, 1'b0, 7'h06);
    run_op("erase_tog", 4'h2, 1'b1, 3, 16'hffff, 0, 1'b0, 7'h46);
    run_op("tmo_stop", 4'h2, 1'b0, 2, 16'h0f0f, 2, 1'b0, 7'h16);
    run_op("tmo_fail", 4'h2, 1'b0, 2, 16'h0081, 1, 1'b0, 7'h1a);
    check("reset cmd", {16'h0, fpsw_flash_model_i.cmd}, 32'hf0);
    check("reset addr", {6'h0, fpsw_flash_model_i.cmd_addr},
          {6'h0, OPA});
    apb(1'b0, fpsw_pkg::REG_LAST, 32'h0, rdv, errv);
    check("last masked", rdv, {24'h0, 1'b0, ~fpsw_flash_model_i.tog6,
          6'h20});
    run_op("buf_abort", 4'h8, 1'b0, 2, 16'h0033, 0, 1'b1, 7'h2a);
    // A stop parks the sequencer with busy and done both low.
    fpsw_flash_model_i.arm(1'b0, 9, 16'h0000, 0, 1'b0, OPA);
    wr(fpsw_pkg::REG_CTRL, 32'h00000005);
    rdv = 32'h1;
    for (int i = 0; i < 50 && rdv[fpsw_pkg::ST_BUSY] !== 1'b0; i++) begin
      apb(1'b0, fpsw_pkg::REG_STATUS, 32'h0, rdv, errv);
    end
    check("stop status", rdv, 32'h0);
    apb(1'b0, fpsw_pkg::REG_CTRL, 32'h0, rdv, errv);
    check("stop ctrl", rdv, 32'h4);
    $display("Test stop finished");
    run_op("restart", 4'h2, 1'b0, 2, 16'h1111, 0, 1'b0, 7'h06);
    close_out();
  end
endmodule
`default_nettype wire
